/* File: fccr_pkg.sv */
package fccr_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] CCS_OFS       = 4'h0;
    localparam logic [3:0] KEY_OFS       = 4'h4;
    localparam logic [3:0] CTRL_OFS      = 4'h8;
    localparam logic [3:0] IRQ_STAT_OFS  = 4'hC;
    localparam logic [3:0] IRQ_MASK_OFS  = 4'h0;
    localparam logic [1:0] PAGE_MAIN     = 2'h0;
    localparam logic [1:0] PAGE_IRQ      = 2'h1;

    // ==========================================================
    // Field positions and values
    localparam int         CCS_ONE_BIT   = 7;
    localparam int         CCS_ERR_BIT   = 4;
    localparam int         CCS_REQ_BIT   = 0;
    localparam int         CTRL_EMU_BIT  = 0;
    localparam int         IRQ_ERR_BIT   = 0;
    localparam int         IRQ_DONE_BIT  = 1;
    localparam logic [7:0] CCS_FIXED     = 8'h80;
    localparam logic [7:0] DL_KEY        = 8'hA5;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // ==========================================================
    // Timing: download copy length, and reset hold the far side keeps
    localparam int         COPY_CYCLES   = 16;
    localparam int         RES_HOLD_US   = 100;
    localparam int         CLK_MHZ       = 50;
    localparam int         RES_HOLD_CYC  = RES_HOLD_US * CLK_MHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        FCCR_IDLE,
        FCCR_COPY
    } fccr_state_e;

    typedef struct packed {
        logic irq_taken;
        logic array_read;
        logic sleep_exec;
        logic other_master;
    } fccr_err_s;

endpackage : fccr_pkg

/* File: fccr_top.sv */
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
// What this block does
// - Registers eight bits, byte accesses only
// - Power-on reset restores all initial values
// - Bit7 reads 1; bits 6,5,3:1 read 0
// - Bit4 read-only error flag; holds protection
// - Error flag cleared only by power-on reset
// - Interrupt during program/erase sets error
// - Flash array read during program/erase sets error
// - Sleep during program/erase sets error
// - Other bus master during program/erase sets error
// - Bit0 download request, write-only, initial 0
// - Request starts copy; clears when done
// - Accept only: no emulation, key A5, from RAM
module fccr_top
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [7:0]         avs_writedata,
    output logic      [7:0]         avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               prog_erase_busy,
    input  wire logic               exec_from_ram,
    input  wire fccr_pkg::fccr_err_s err_src,
    output logic                    error_protect,
    output logic                    download_busy,
    output logic                    irq
);
    import fccr_pkg::*;

    // ==========================================================
    // State
    localparam int SYNC_W = 6;

    // Pin synchronisers
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s1_ff;
    logic [SYNC_W-1:0] pin_s2_ff;
    fccr_err_s         src_sync;
    logic              busy_sync;
    logic              ram_sync;

    // Bus handshake
    logic              req;
    logic              take;
    logic              commit_wr;
    logic              ack_ff;
    logic              nxt_ack;
    logic [7:0]        rdata_ff;
    logic [7:0]        nxt_rdata;

    // Software registers
    logic [7:0]        key_ff;
    logic [7:0]        nxt_key;
    logic              emu_ff;
    logic              nxt_emu;
    logic              page_ff;
    logic              nxt_page;
    logic [1:0]        mask_ff;
    logic [1:0]        nxt_mask;
    logic [1:0]        stat_ff;
    logic [1:0]        nxt_stat;

    // Download engine
    fccr_state_e       state_ff;
    fccr_state_e       nxt_state;
    logic [4:0]        cnt_ff;
    logic [4:0]        nxt_cnt;
    logic              wr_ccs;
    logic              dl_ok;
    logic              done_evt;

    // Error flag
    logic              err_ff;
    logic              nxt_err;
    logic              err_evt;

    // Output registers
    logic              busy_ff;
    logic              nxt_busy;
    logic              irq_ff;
    logic              nxt_irq;

    // ==========================================================
    // Pin synchronisers, two flops per bit
    // Busy, RAM execution and error sources come from other logic
    // that does not share this clock
    assign pin_raw = {prog_erase_busy, exec_from_ram, err_src};

    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (rst) begin
                pin_s1_ff[i] <= 1'b0;
                pin_s2_ff[i] <= 1'b0;
            end else begin
                pin_s1_ff[i] <= pin_raw[i];
                pin_s2_ff[i] <= pin_s1_ff[i];
            end
        end
    end

    // Only the second stage is read
    assign busy_sync = pin_s2_ff[5];
    assign ram_sync  = pin_s2_ff[4];
    assign src_sync  = pin_s2_ff[3:0];

    // ==========================================================
    // Bus handshake: one wait state, commit while waitrequest is low
    // A write lands only at the edge that sees waitrequest low
    assign req       = avs_read || avs_write;
    assign take      = req && !ack_ff;
    assign commit_wr = avs_write && ack_ff;

    // Read data captured when the request is taken
    always_comb begin
        nxt_ack   = take;
        nxt_rdata = rdata_ff;
        if (take) begin
            nxt_rdata = RST_ZERO;
            if (avs_read) begin
                if (page_ff) begin
                    unique case (avs_address)
                        IRQ_MASK_OFS: nxt_rdata = {6'h00, mask_ff};
                        IRQ_STAT_OFS: nxt_rdata = {6'h00, stat_ff};
                        CTRL_OFS:     nxt_rdata = {6'h00, page_ff, 1'b0};
                        default:      nxt_rdata = RST_ZERO;
                    endcase
                end else begin
                    unique case (avs_address)
                        // Request bit reads 0, fixed bits constant
                        CCS_OFS:  nxt_rdata = CCS_FIXED | {3'h0, err_ff, 4'h0};
                        KEY_OFS:  nxt_rdata = key_ff;
                        CTRL_OFS: nxt_rdata = {6'h00, page_ff, emu_ff};
                        default:  nxt_rdata = RST_ZERO;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= RST_ZERO;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Software registers, written at the acknowledge edge
    always_comb begin
        nxt_key  = key_ff;
        nxt_emu  = emu_ff;
        nxt_page = page_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        if (commit_wr) begin
            if (page_ff) begin
                if (avs_address == IRQ_MASK_OFS) begin
                    nxt_mask = avs_writedata[1:0];
                end
                if (avs_address == IRQ_STAT_OFS) begin
                    nxt_stat = stat_ff & ~avs_writedata[1:0];
                end
                if (avs_address == CTRL_OFS) begin
                    nxt_page = avs_writedata[1];
                end
            end else begin
                if (avs_address == KEY_OFS) begin
                    nxt_key = avs_writedata;
                end
                if (avs_address == CTRL_OFS) begin
                    nxt_emu  = avs_writedata[CTRL_EMU_BIT];
                    nxt_page = avs_writedata[1];
                end
            end
        end
        // Set wins over clear
        if (err_evt && !err_ff) begin
            nxt_stat[IRQ_ERR_BIT] = 1'b1;
        end
        if (done_evt) begin
            nxt_stat[IRQ_DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            key_ff  <= RST_ZERO;
            emu_ff  <= 1'b0;
            page_ff <= 1'b0;
            mask_ff <= 2'h0;
            stat_ff <= 2'h0;
        end else begin
            key_ff  <= nxt_key;
            emu_ff  <= nxt_emu;
            page_ff <= nxt_page;
            mask_ff <= nxt_mask;
            stat_ff <= nxt_stat;
        end
    end

    // ==========================================================
    // Download engine
    assign wr_ccs = commit_wr && !page_ff && avs_address == CCS_OFS;
    // Refused silently unless every start condition holds
    assign dl_ok  = avs_writedata[CCS_REQ_BIT] && !emu_ff && key_ff == DL_KEY
                    && ram_sync;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        done_evt  = 1'b0;
        unique case (state_ff)
            FCCR_IDLE: begin
                if (wr_ccs && dl_ok) begin
                    nxt_state = FCCR_COPY;
                    nxt_cnt   = 5'(COPY_CYCLES - 1);
                end
            end
            FCCR_COPY: begin
                if (cnt_ff == 5'h0) begin
                    nxt_state = FCCR_IDLE;
                    done_evt  = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 5'h1;
                end
            end
            default: begin
                nxt_state = FCCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= FCCR_IDLE;
            cnt_ff   <= 5'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ==========================================================
    // Error flag, sticky until power-on reset
    // Any source while programming latches the error
    assign err_evt = busy_sync && (src_sync.irq_taken
                                || src_sync.array_read
                                || src_sync.sleep_exec
                                || src_sync.other_master);

    always_comb begin
        nxt_err = err_ff;
        if (err_evt) begin
            nxt_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= nxt_err;
        end
    end

    // ==========================================================
    // Output registers, loaded from next values so no cycle is lost
    always_comb begin
        nxt_busy = (nxt_state == FCCR_COPY);
        nxt_irq  = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            irq_ff  <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
            irq_ff  <= nxt_irq;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_waitrequest = take;
    assign avs_readdata    = rdata_ff;
    assign error_protect   = err_ff;
    assign download_busy   = busy_ff;
    assign irq             = irq_ff;

endmodule : fccr_top

/* File: fccr_properties.sv */
`timescale 1ns/1ns
module fccr_props
(
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic [3:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest,
    input wire logic                prog_erase_busy,
    input wire fccr_pkg::fccr_err_s err_src,
    input wire logic                error_protect,
    input wire logic                download_busy,
    input wire logic                irq
);
    import fccr_pkg::*;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Copy length counter
    always_comb nxt_cnt = download_busy ? cnt_ff + 5'h1 : 5'h0;
    always_ff @(posedge core_clk) cnt_ff <= rst ? 5'h0 : nxt_cnt;
    // ==========================================
    // Properties
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait too long");
    a_wait_idle: assert property (!avs_read && !avs_write
        |-> !avs_waitrequest) else $error("wait when idle");
    a_rst_values: assert property ($fell(rst)
        |-> !error_protect && !download_busy && !irq) else $error("bad reset");
    a_err_sticky: assert property (error_protect |=> error_protect)
        else $error("flag lost");
    a_err_set: assert property ((prog_erase_busy && |err_src)[*4]
        |=> error_protect) else $error("flag not set");
    a_err_cause: assert property ($rose(error_protect)
        |-> $past(prog_erase_busy, 3)) else $error("flag while idle");
    a_copy_len: assert property ($fell(download_busy)
        |-> cnt_ff == COPY_CYCLES) else $error("copy length");
    a_busy_start: assert property ($rose(download_busy)
        |-> $past(avs_write) && !$past(avs_waitrequest)
            && $past(avs_address) == CCS_OFS) else $error("copy start");
endmodule : fccr_props

bind fccr_top fccr_props i_props (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_waitrequest, .prog_erase_busy, .err_src, .error_protect,
    .download_busy, .irq);

/* File: fccr_cpu_model.sv */
`timescale 1ns/1ns
module fccr_cpu_model
(
    input wire logic             core_clk,
    output logic                 prog_erase_busy = 1'b0,
    output logic                 exec_from_ram = 1'b1,
    output fccr_pkg::fccr_err_s  err_src = '0
);
    import fccr_pkg::*;
    // Interrupts quiet unless asked
    task automatic run(input logic b, input logic r, input logic [3:0] s);
        @(posedge core_clk);
        prog_erase_busy <= b;
        exec_from_ram <= r;
        err_src <= s;
    endtask : run
endmodule : fccr_cpu_model

/* File: fccr_top_bench.sv */
`timescale 1ns/1ns
module fccr_top_bench;
    import fccr_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       avs_read = 1'b0;
    logic       avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [7:0] avs_writedata = 8'h00;
    logic [7:0] avs_readdata;
    logic [7:0] rd;
    logic       avs_waitrequest, prog_erase_busy, exec_from_ram;
    logic       error_protect, download_busy, irq;
    fccr_err_s  err_src;
    int         num_errors = 0;
    int         checked = 0;
    int         cycles = 0;
    fccr_top i_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .prog_erase_busy,
        .exec_from_ram, .err_src, .error_protect, .download_busy, .irq);
    fccr_cpu_model i_cpu (.core_clk, .prog_erase_busy, .exec_from_ram, .err_src);
    always #10 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
        checked = checked + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : acc
    task automatic rc(input string w, input logic [3:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(w, rd, e);
    endtask : rc
    task automatic reset_for(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst <= 1'b0;
    endtask : reset_for
    initial begin
        reset_for(20);
        rc("ccs reset", CCS_OFS, CCS_FIXED);
        acc(1'b1, CCS_OFS, 8'hFE);
        rc("ccs fixed", CCS_OFS, CCS_FIXED);
        for (int k = 0; k < 3; k++) begin
            i_cpu.run(1'b0, k != 2, 4'h0);
            acc(1'b1, CTRL_OFS, k == 0 ? 8'h01 : 8'h00);
            acc(1'b1, KEY_OFS, k == 1 ? 8'h5A : DL_KEY);
            acc(1'b1, CCS_OFS, 8'h01);
            repeat (4) @(posedge core_clk);
            chk("refused", {7'h00, download_busy}, 8'h00);
        end
        i_cpu.run(1'b0, 1'b1, 4'h0);
        acc(1'b1, KEY_OFS, DL_KEY);
        acc(1'b1, CCS_OFS, 8'h01);
        @(posedge core_clk);
        chk("busy", {7'h00, download_busy}, 8'h01);
        rc("dummy", CCS_OFS, CCS_FIXED);
        rc("dummy", CCS_OFS, CCS_FIXED);
        repeat (20) @(posedge core_clk);
        chk("done", {7'h00, download_busy}, 8'h00);
        acc(1'b1, CTRL_OFS, 8'h02);
        rc("stat", IRQ_STAT_OFS, 8'h02);
        chk("masked", {7'h00, irq}, 8'h00);
        acc(1'b1, IRQ_MASK_OFS, 8'h02);
        repeat (2) @(posedge core_clk);
        chk("irq", {7'h00, irq}, 8'h01);
        acc(1'b1, IRQ_STAT_OFS, 8'h02);
        repeat (2) @(posedge core_clk);
        chk("cleared", {7'h00, irq}, 8'h00);
        rc("unmapped", 4'h4, 8'h00);
        acc(1'b1, CTRL_OFS, 8'h00);
        for (int k = 0; k < 4; k++) begin
            i_cpu.run(1'b0, 1'b1, 4'h1 << k);
            repeat (6) @(posedge core_clk);
            chk("idle", {7'h00, error_protect}, 8'h00);
            i_cpu.run(1'b1, 1'b1, 4'h1 << k);
            repeat (6) @(posedge core_clk);
            i_cpu.run(1'b0, 1'b1, 4'h0);
            acc(1'b1, CCS_OFS, 8'h00);
            rc("err", CCS_OFS, 8'h90);
            acc(1'b1, CTRL_OFS, 8'h02);
            rc("err stat", IRQ_STAT_OFS, 8'h01);
            reset_for(RES_HOLD_CYC);
            rc("por", CCS_OFS, CCS_FIXED);
        end
        report_and_stop();
    end
endmodule : fccr_top_bench
